// >>> rtl/arsc_conv_seq.sv
`timescale 1ns/100ps
`default_nettype none
module arsc_conv_seq
  import arsc_pkg::*;
#(
  parameter int DIV = arsc_pkg::ADC_CLK_DIV
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic start,
  output logic busy_r,
  output logic done
);

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1);
  localparam logic [4:0] LAST_NORMAL = 5'(CONV_CLOCKS - 1);
  localparam logic [4:0] LAST_FIRST = 5'(FIRST_CONV_CLOCKS - 1);

  arsc_seq_state_t state_r;
  logic [7:0] div_r;
  logic [4:0] cnt_r;
  logic first_r;

  // converter clock enable and end of conversion
  wire logic tick = (div_r == DIV_LAST);
  wire logic [4:0] cnt_last = first_r ? LAST_FIRST : LAST_NORMAL;
  assign done = (state_r == SEQ_CONVERT) && enable && tick && (cnt_r == cnt_last);

  // divider for the converter clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_r <= 8'h00;
    else
      div_r <= tick ? 8'h00 : div_r + 8'h01;
  end

  // sequencer: disable aborts, first conversion after enable is longer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= SEQ_IDLE;
      cnt_r <= 5'h00;
      first_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else if (!enable)
    begin
      state_r <= SEQ_IDLE;
      first_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        SEQ_IDLE:
        begin
          if (start)
          begin
            state_r <= SEQ_CONVERT;
            cnt_r <= 5'h00;
            busy_r <= 1'b1;
          end
        end
        SEQ_CONVERT:
        begin
          if (done)
          begin
            state_r <= SEQ_IDLE;
            first_r <= 1'b0;
            busy_r <= 1'b0;
          end
          else if (tick)
            cnt_r <= cnt_r + 5'h01;
        end
        default:
          state_r <= SEQ_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> rtl/arsc_pkg.sv
`default_nettype none
package arsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_INPUT_SEL = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_RES_LO = 8'h08;
  localparam logic [7:0] OFS_RES_HI = 8'h0c;
  localparam logic [7:0] OFS_INT_MASK = 8'h10;
  localparam logic [7:0] OFS_INT_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ALIGN_BIT = 5;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int INT_DONE_BIT = 0;
  localparam logic [7:0] INPUT_SEL_RESET = 8'h00;
  localparam logic [4:0] DIFF_FIRST = 5'h08;
  localparam logic [4:0] DIFF_LAST = 5'h1d;

  // ----------------------------------------------------------------
  // code ranges and conversion timing
  // ----------------------------------------------------------------
  localparam logic [9:0] CODE_MIN_SE = 10'h000;
  localparam logic [9:0] CODE_MAX_SE = 10'h3ff;
  localparam logic [9:0] CODE_MIN_DIFF = 10'h200;
  localparam logic [9:0] CODE_MAX_DIFF = 10'h1ff;
  localparam int SAMPLE_W = 12;
  localparam int CONV_CLOCKS = 13;
  localparam int FIRST_CONV_CLOCKS = 25;
  localparam int ADC_CLK_DIV = 8;

  typedef enum logic [1:0] {
    REF_EXTERNAL_PIN = 2'b00,
    REF_ANALOG_SUPPLY = 2'b01,
    REF_RESERVED = 2'b10,
    REF_INTERNAL_2V56 = 2'b11
  } arsc_ref_t;

  typedef struct packed {
    arsc_ref_t reference_select;
    logic result_left_align;
    logic [4:0] channel_gain_select;
  } arsc_input_select_t;

  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } arsc_result_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CONVERT = 2'b01
  } arsc_seq_state_t;

  // channel codes that select a differential pair
  function automatic logic arsc_is_diff(input logic [4:0] chan);
    arsc_is_diff = (chan >= DIFF_FIRST) && (chan <= DIFF_LAST);
  endfunction

  // place a 10-bit code across the two result bytes
  function automatic arsc_result_t arsc_align(input logic [9:0] code, input logic left);
    arsc_result_t r;
    if (left)
    begin
      r.result_high_byte = code[9:2];
      r.result_low_byte = {code[1:0], 6'h00};
    end
    else
    begin
      r.result_high_byte = {6'h00, code[9:8]};
      r.result_low_byte = code[7:0];
    end
    arsc_align = r;
  endfunction

endpackage
`default_nettype wire

// >>> rtl/arsc_result_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module arsc_result_fmt
  import arsc_pkg::*;
#(
  parameter int SW = arsc_pkg::SAMPLE_W
)
(
  input wire logic signed [SW-1:0] sample,
  input wire logic is_diff,
  output logic [9:0] code
);

  // ----------------------------------------------------------------
  // saturation bounds
  // ----------------------------------------------------------------
  localparam logic signed [SW-1:0] SE_TOP = SW'(1023);
  localparam logic signed [SW-1:0] DIFF_TOP = SW'(511);
  localparam logic signed [SW-1:0] DIFF_BOT = -SW'(512);

  wire logic se_low = sample < 0;
  wire logic se_high = sample > SE_TOP;
  wire logic diff_high = sample > DIFF_TOP;
  wire logic diff_low = sample < DIFF_BOT;

  // unsigned clamp for single ended, two's complement clamp for pairs
  wire logic [9:0] se_code = se_low ? CODE_MIN_SE : (se_high ? CODE_MAX_SE : sample[9:0]);
  wire logic [9:0] diff_code = diff_high ? CODE_MAX_DIFF :
                               (diff_low ? CODE_MIN_DIFF : sample[9:0]);
  assign code = is_diff ? diff_code : se_code;

endmodule
`default_nettype wire

// >>> rtl/arsc_top.sv
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module arsc_top
  import arsc_pkg::*;
#(
  parameter int DIV = arsc_pkg::ADC_CLK_DIV
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [arsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic [arsc_pkg::SAMPLE_W-1:0] analog_sample,
  output arsc_pkg::arsc_ref_t reference_select_out,
  output logic [4:0] channel_gain_out,
  output logic convert_active
);
  import arsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arsc_input_select_t input_sel_r;
  arsc_ref_t active_ref_r;
  logic [4:0] active_chan_r;
  logic [9:0] result_r;
  logic enable_r;
  logic int_status_r;
  logic int_mask_r;
  logic irq_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [SAMPLE_W-1:0] sample_meta_r;
  logic [SAMPLE_W-1:0] sample_sync_r;
  logic busy;
  logic done;
  logic [9:0] fmt_code;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  wire logic apb_access = psel & penable;
  wire logic bus_take = apb_access & pready_r;
  wire logic rd_load = apb_access & ~pready_r & ~pwrite;
  wire logic wr_take = bus_take & pwrite;
  wire logic hit_input_sel = (paddr == OFS_INPUT_SEL);
  wire logic hit_ctrl = (paddr == OFS_CTRL);
  wire logic hit_res_lo = (paddr == OFS_RES_LO);
  wire logic hit_res_hi = (paddr == OFS_RES_HI);
  wire logic hit_mask = (paddr == OFS_INT_MASK);
  wire logic hit_status = (paddr == OFS_INT_STATUS);
  wire logic mapped = hit_input_sel | hit_ctrl | hit_res_lo | hit_res_hi | hit_mask | hit_status;
  wire logic wr_input_sel = wr_take & hit_input_sel;
  wire logic wr_ctrl = wr_take & hit_ctrl;
  wire logic wr_mask = wr_take & hit_mask;
  wire logic wr_status = wr_take & hit_status;
  wire logic start_req = wr_ctrl & pwdata[CTRL_START_BIT];
  wire logic enable_nxt = wr_ctrl ? pwdata[CTRL_EN_BIT] : enable_r;

  // ----------------------------------------------------------------
  // result presentation and read mux
  // ----------------------------------------------------------------
  // alignment reads the live bit, not a locked copy
  wire arsc_result_t res_bytes = arsc_align(result_r, input_sel_r.result_left_align);
  wire logic is_diff_active = arsc_is_diff(active_chan_r);
  wire logic [31:0] rd_value =
    hit_input_sel ? {24'h000000, input_sel_r} :
    hit_ctrl ? {30'h00000000, busy, enable_r} :
    hit_res_lo ? {24'h000000, res_bytes.result_low_byte} :
    hit_res_hi ? {24'h000000, res_bytes.result_high_byte} :
    hit_mask ? {31'h00000000, int_mask_r} :
    hit_status ? {31'h00000000, int_status_r} :
    32'h00000000;

  // ----------------------------------------------------------------
  // sticky done flag: set wins over a write-one clear
  // ----------------------------------------------------------------
  wire logic status_clear = wr_status & pwdata[INT_DONE_BIT];
  wire logic int_status_nxt = done | (int_status_r & ~status_clear);
  wire logic int_mask_nxt = wr_mask ? pwdata[INT_DONE_BIT] : int_mask_r;
  wire logic irq_nxt = int_status_nxt & int_mask_nxt; // irq tracks flag and mask with no lag

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  // conversion timing on the divided converter clock
  arsc_conv_seq #(
    .DIV(DIV)
  ) u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .enable(enable_r),
    .start(start_req),
    .busy_r(busy),
    .done(done)
  );

  // coding and saturation of the synchronised sample
  arsc_result_fmt #(
    .SW(SAMPLE_W)
  ) u_fmt (
    .sample(sample_sync_r),
    .is_diff(is_diff_active),
    .code(fmt_code)
  );

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  // pready and read data are registered so outputs come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      pready_r <= apb_access & ~pready_r;
      pslverr_r <= apb_access & ~pready_r & ~mapped;
      if (rd_load)
        prdata_r <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // input select, control enable, interrupt mask and status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_sel_r <= INPUT_SEL_RESET;
      enable_r <= 1'b0;
      int_mask_r <= 1'b0;
      int_status_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (wr_input_sel)
        input_sel_r <= pwdata[7:0];
      enable_r <= enable_nxt;
      int_mask_r <= int_mask_nxt;
      int_status_r <= int_status_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ----------------------------------------------------------------
  // analog side: sample synchroniser and locked selection
  // ----------------------------------------------------------------
  // two flops before the sample is read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_meta_r <= '0;
      sample_sync_r <= '0;
    end
    else
    begin
      sample_meta_r <= analog_sample;
      sample_sync_r <= sample_meta_r;
    end
  end

  // selection follows software while idle, frozen while converting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_ref_r <= REF_EXTERNAL_PIN;
      active_chan_r <= 5'h00;
    end
    else if (!busy || done)
    begin
      active_ref_r <= input_sel_r.reference_select;
      active_chan_r <= input_sel_r.channel_gain_select;
    end
  end

  // result captured in the same cycle as the done flag sets
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      result_r <= 10'h000;
    else if (done)
      result_r <= fmt_code;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a flop, forwarded unchanged
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign reference_select_out = active_ref_r;
  assign channel_gain_out = active_chan_r;
  assign convert_active = busy;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // signed view of the sample for range checks
  wire logic signed [SAMPLE_W-1:0] ssample = sample_sync_r;

  // coding and saturation of each completed result
  AST_RESULT_AT_DONE:
  assert property (done |=> result_r == $past(fmt_code) && int_status_r)
    else $error("result not loaded with done flag");

  AST_SE_LOW_CLAMP:
  assert property (done && !is_diff_active && ssample < 0 |=> result_r == 10'h000)
    else $error("single ended negative sample not clamped to zero");

  AST_SE_HIGH_CLAMP:
  assert property (done && !is_diff_active && ssample > 1023 |=> result_r == 10'h3ff)
    else $error("single ended overrange not clamped to full scale");

  AST_DIFF_SAT:
  assert property (done && is_diff_active && ssample < -512 |=> result_r == 10'h200)
    else $error("differential underrange not saturated");

  AST_DIFF_HIGH_SAT:
  assert property (done && is_diff_active && ssample > 511 |=> result_r == 10'h1ff)
    else $error("differential overrange not saturated");

  AST_SE_PASS:
  assert property (done && !is_diff_active && ssample >= 0 && ssample <= 1023
                   |=> result_r == $past(sample_sync_r[9:0]))
    else $error("single ended in-range code altered");

  AST_DIFF_PASS:
  assert property (done && is_diff_active && ssample >= -512 && ssample <= 511
                   |=> result_r == $past(sample_sync_r[9:0]))
    else $error("differential in-range code altered");

  AST_DIFF_SIGN:
  assert property (done && is_diff_active |=> result_r[9] == $past(sample_sync_r[SAMPLE_W-1]))
    else $error("differential sign bit wrong");

  // register writes and locked selection
  AST_INPUT_SEL_WRITE:
  assert property (wr_input_sel |=> input_sel_r == $past(pwdata[7:0]))
    else $error("input select write lost");

  AST_REF_LOCKED:
  assert property (busy && !done |=> active_ref_r == $past(active_ref_r))
    else $error("reference changed during conversion");

  AST_CHAN_LOCKED:
  assert property (busy && !done |=> active_chan_r == $past(active_chan_r))
    else $error("channel changed during conversion");

  AST_SEL_HOLD:
  assert property (!wr_input_sel |=> $stable(input_sel_r))
    else $error("input select changed without a write");

  AST_REF_RELOAD:
  assert property (done |=> active_ref_r == $past(input_sel_r.reference_select))
    else $error("reference not reloaded at completion");

  AST_CHAN_RELOAD:
  assert property (done |=> active_chan_r == $past(input_sel_r.channel_gain_select))
    else $error("channel not reloaded at completion");

  AST_LEFT_ALIGN:
  assert property (input_sel_r.result_left_align |-> res_bytes.result_high_byte == result_r[9:2]
                   && res_bytes.result_low_byte[5:0] == 6'h00)
    else $error("left aligned layout wrong");

  AST_ALIGN_IMMEDIATE:
  assert property (wr_input_sel && busy |=> input_sel_r.result_left_align == $past(pwdata[5]))
    else $error("alignment change delayed by conversion");

  AST_RIGHT_ALIGN:
  assert property (!input_sel_r.result_left_align
                   |-> res_bytes.result_low_byte == result_r[7:0]
                   && res_bytes.result_high_byte == {6'h00, result_r[9:8]})
    else $error("right aligned layout wrong");

  AST_LEFT_LOW_BITS:
  assert property (input_sel_r.result_left_align
                   |-> res_bytes.result_low_byte[7:6] == result_r[1:0])
    else $error("left aligned low bits wrong");

  // flag, interrupt and bus response
  AST_DONE_STICKY:
  assert property (int_status_r && !status_clear |=> int_status_r)
    else $error("done flag dropped without clear");

  AST_RESULT_HOLD:
  assert property (!done |=> result_r == $past(result_r))
    else $error("result changed without conversion");

  AST_IRQ_LEVEL:
  assert property (irq_r == (int_status_r && int_mask_r))
    else $error("interrupt level does not match flag and mask");

  AST_READY_ONE_CYCLE:
  assert property (pready_r |=> !pready_r)
    else $error("pready held longer than one cycle");

  AST_SLVERR_WITH_READY:
  assert property (pslverr_r |-> pready_r)
    else $error("pslverr without pready");

  AST_RESULT_READ:
  assert property (rd_load && hit_res_lo
                   |=> prdata_r == {24'h000000, $past(res_bytes.result_low_byte)})
    else $error("result low byte read data wrong");

  AST_START_BUSY:
  assert property (start_req && enable_r && !busy |=> busy)
    else $error("accepted start did not raise busy");

endmodule
`default_nettype wire

// >>> verification/arsc_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
module arsc_analog_model
  import arsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic convert_active,
  input wire logic [arsc_pkg::SAMPLE_W-1:0] level,
  output logic [arsc_pkg::SAMPLE_W-1:0] analog_sample
);
  import arsc_pkg::*;

  // source level only moves between conversions, never while one runs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      analog_sample <= '0;
    else if (!convert_active)
      analog_sample <= level;
  end
endmodule
`default_nettype wire

// >>> verification/arsc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module arsc_top_tb;
  import arsc_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, irq, pready, pslverr;
  logic convert_active, err;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d;
  logic [SAMPLE_W-1:0] level = '0, analog_sample;
  arsc_ref_t reference_select_out;
  logic [4:0] channel_gain_out;
  int num_errors = 0, checks_done = 0, cyc = 0;
  logic [7:0] sel_t [9] = '{8'h01, 8'h01, 8'h01, 8'h10, 8'h10, 8'h10, 8'h1d, 8'h1e, 8'h08};
  logic [11:0] lv_t [9] = '{12'h123, 12'h500, 12'hfff, 12'he70, 12'hda8, 12'h258, 12'hda8,
    12'hfff, 12'hfff};
  logic [9:0] code_t [9] = '{10'h123, 10'h3ff, 10'h000, 10'h270, 10'h200, 10'h1ff, 10'h200,
    10'h000, 10'h3ff};

  arsc_top #(.DIV(2)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .analog_sample(analog_sample),
    .reference_select_out(reference_select_out), .channel_gain_out(channel_gain_out),
    .convert_active(convert_active));

  arsc_analog_model partner (.pclk(pclk), .presetn(presetn), .convert_active(convert_active),
    .level(level), .analog_sample(analog_sample));

  // clock and hang guard
  initial
  begin
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1, a, wd);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(0, a, 32'h0);
  endtask

  task automatic start(input logic [11:0] lv);
    level <= lv;
    wr(OFS_CTRL, 32'h3);
  endtask

  // wait for the end of a conversion, then check and clear the flag
  task automatic finish(input logic ei);
    int n;
    repeat (2) @(negedge pclk);
    n = 0;
    while (convert_active !== 1'b0 && n < 300)
    begin
      @(negedge pclk);
      n++;
    end
    rd(OFS_INT_STATUS);
    chk("done flag", 32'h1, d);
    chk("irq", {31'h0, ei}, {31'h0, irq});
    wr(OFS_INT_STATUS, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask

  task automatic res(input logic [9:0] c);
    rd(OFS_RES_LO);
    chk("result low", {24'h0, c[7:0]}, d);
    rd(OFS_RES_HI);
    chk("result high", {30'h0, c[9:8]}, d);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(OFS_INPUT_SEL);
    chk("input select reset", 32'h0, d);
    wr(OFS_INPUT_SEL, 32'hff);
    rd(OFS_INPUT_SEL);
    chk("input select rw", 32'hff, d);
    for (int r = 0; r < 4; r++)
    begin
      wr(OFS_INPUT_SEL, {24'h0, r[1:0], 6'h0});
      repeat (2) @(negedge pclk);
      chk("reference out", r, {30'h0, reference_select_out});
    end
    rd(8'h18);
    chk("unmapped error", 32'h1, {31'h0, err});
    wr(OFS_INT_MASK, 32'h1);
    wr(OFS_CTRL, 32'h1);
    for (int i = 0; i < 9; i++)
    begin
      wr(OFS_INPUT_SEL, {24'h0, sel_t[i]});
      start(lv_t[i]);
      finish(1);
      res(code_t[i]);
    end
    // left adjusted result, then realigned without a conversion
    wr(OFS_INPUT_SEL, 32'h30);
    start(12'he70);
    finish(1);
    rd(OFS_RES_HI);
    chk("left high", 32'h9c, d);
    rd(OFS_RES_LO);
    chk("left low", 32'h00, d);
    level <= 12'h123;
    wr(OFS_INPUT_SEL, 32'h10);
    res(10'h270);
    // selection rewritten while a conversion runs
    wr(OFS_INPUT_SEL, 32'h50);
    start(12'he70);
    wr(OFS_INPUT_SEL, 32'hc1);
    chk("ref held", 32'h1, {30'h0, reference_select_out});
    chk("chan held", 32'h10, {27'h0, channel_gain_out});
    finish(1);
    chk("ref after", 32'h3, {30'h0, reference_select_out});
    chk("chan after", 32'h1, {27'h0, channel_gain_out});
    res(10'h270);
    // masked completion keeps irq low
    wr(OFS_INT_MASK, 32'h0);
    start(12'h123);
    finish(0);
    res(10'h123);
    // disable during a conversion aborts it with no flag and no new result
    start(12'h200);
    wr(OFS_CTRL, 32'h0);
    repeat (60) @(posedge pclk);
    rd(OFS_INT_STATUS);
    chk("abort no flag", 32'h0, d);
    rd(OFS_CTRL);
    chk("abort idle", 32'h0, d);
    res(10'h123);
    // left adjusted low bits of the stored result
    wr(OFS_INPUT_SEL, 32'he1);
    rd(OFS_RES_LO);
    chk("left low bits", 32'hc0, d);
    rd(OFS_RES_HI);
    chk("left high bits", 32'h48, d);
    // second reset in mid-run returns the selection to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_INPUT_SEL);
    chk("input select after reset", 32'h0, d);
    chk("reference after reset", 32'h0, {30'h0, reference_select_out});
    conclude();
  end
endmodule
`default_nettype wire
